// *** pm_pkg.sv ***
// package for the operating-mode and clock controller
// assumes an axi4-lite master with 12-bit byte addresses, 32-bit data
package pm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_A       = 12'h038;
  localparam logic [11:0] IDX_B       = 12'h039;
  localparam logic [11:0] ADDR_A      = IDX_A << 2;
  localparam logic [11:0] ADDR_B      = IDX_B << 2;
  localparam logic [7:0]  PCRA_RESET  = 8'h00;
  localparam logic [7:0]  PCRB_RESET  = 8'h80;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // short slow warm-up counts, in slow-clock periods
  localparam int          WARM_W       = 18;
  localparam logic [17:0] WARM_SLOW_10 = 18'h0_00c0;
  localparam logic [17:0] WARM_SLOW_11 = 18'h0_0040;

  ////////////////////////////////////////////////////////////////////////////
  // field layouts, msb first, matching bit positions 7..0
  typedef struct packed {
    logic       deep_halt_request;
    logic       wake_level_select;
    logic       wake_target_select;
    logic       halt_output_hold;
    logic [1:0] warmup_select;
    logic [1:0] unused_lo;
  } pcra_t;

  typedef struct packed {
    logic       fast_osc_on;
    logic       slow_osc_on;
    logic       core_clock_select;
    logic       cpu_doze_request;
    logic       unused_3;
    logic       peripheral_clock_gate;
    logic [1:0] unused_lo;
  } pcrb_t;

  // operating states
  typedef enum logic [3:0] {
    fast_single_run, fast_dual_run, slow_only_run, slow_dual_run,
    fast_base_doze, fast_single_doze, fast_dual_doze,
    slow_base_doze, slow_only_doze, slow_dual_doze,
    deep_halt, warm_up
  } power_mode_t;

endpackage

// *** power_mode_control.sv ***
// operating-mode and clock controller with an axi4-lite register slave
// assumes tick inputs pulse once per oscillator period in the aclk domain
`timescale 1ns/1ps

// Contract
// R1 - deep_halt_request stops core, peripherals: deep halt
// R2 - wake_level_select picks edge or level release
// R3 - wake_target_select picks fast run or slow_only_run
// R4 - halt_output_hold: float or keep port outputs
// R5 - warmup_select sets warm-up length per target
// R6 - software sets target to match current run
// R7 - reset pin always returns to fast_single_run
// R8 - register a low two bits read undefined
// R9 - float mode forces port inputs to zero
// R10 - wake pin floats throughout deep halt
// R11 - fast_osc_on switches fast oscillator
// R12 - slow_osc_on switches slow oscillator
// R13 - core_clock_select writes choice, reads clock used
// R14 - cpu_doze_request stops cpu, watchdog: doze
// R15 - peripheral_clock_gate stops peripherals but time base
// R16 - removing the running clock's oscillator resets
// R17 - register b bits 3,1,0 read undefined
// R18 - never set doze and gate together
// R19 - doze exit clears cpu_doze_request
// R20 - base doze exit clears peripheral_clock_gate
// R21 - base doze exit timed asynchronously, may shorten
// R22 - software stops peripherals before gating
// R23 - time-base falling edge ends base doze
// R24 - prescaler and divider cleared in deep halt
// R25 - edge release on rising edge; enter if high
// R26 - state machine derives every operating state
module power_mode_control #(
  parameter logic [17:0] WARM_FAST_00 = 18'h3_0000,
  parameter logic [17:0] WARM_FAST_01 = 18'h1_0000,
  parameter logic [17:0] WARM_FAST_10 = 18'h0_c000,
  parameter logic [17:0] WARM_FAST_11 = 18'h0_4000,
  parameter logic [17:0] WARM_SLOW_00 = 18'h0_6000,
  parameter logic [17:0] WARM_SLOW_01 = 18'h0_2000
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write
  input  wire logic [11:0]        awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  // axi4-lite read
  input  wire logic [11:0]        araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // asynchronous pins
  input  wire logic               wake_pin_in,
  input  wire logic               reset_pin_n,
  input  wire logic               tb_source_clk,
  // same-domain events
  input  wire logic               wake_irq,
  input  wire logic               fast_tick,
  input  wire logic               slow_tick,
  // clock and power controls
  output logic                    fast_osc_enable,
  output logic                    slow_osc_enable,
  output logic                    core_clk_slow,
  output logic                    cpu_wdt_stop,
  output logic                    periph_clk_stop,
  output logic                    port_out_hiz,
  output logic                    port_in_zero,
  output logic                    wake_pin_hiz,
  output logic                    prescaler_clear,
  output logic                    warmup_busy,
  output logic                    system_reset_req,
  output pm_pkg::power_mode_t     mode
);

  ////////////////////////////////////////////////////////////////////////////
  pm_pkg::power_mode_t state;
  pm_pkg::pcra_t       ra;
  pm_pkg::pcrb_t       rb;
  pm_pkg::pcrb_t       nb;
  logic                clk_slow;
  logic [2:0]          pin_meta;
  logic [2:0]          pin_sync;
  logic [2:0]          pin_last;
  logic                wake_s;
  logic                rst_pin_s;
  logic                wake_rise;
  logic                tb_fall;
  logic                soft_rst;
  logic                rst_req;
  logic                aw_ok;
  logic                w_ok;
  logic [11:0]         aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                do_write;
  logic                wr_a;
  logic                wr_b;
  logic                bad_write;
  logic                is_run;
  logic                is_doze;
  logic                is_base;
  logic [17:0]         warm_cnt;
  logic [17:0]         warm_limit;
  logic                warm_tick;
  logic                warm_done;

  // run state for given enables and clock
  function automatic pm_pkg::power_mode_t run_of(input logic f, input logic s,
                                                 input logic slow);
    if (slow) return f ? pm_pkg::slow_dual_run : pm_pkg::slow_only_run;
    return s ? pm_pkg::fast_dual_run : pm_pkg::fast_single_run;
  endfunction

  // doze state matching a run state
  function automatic pm_pkg::power_mode_t doze_of(input logic f, input logic s,
                                                  input logic slow);
    if (slow) return f ? pm_pkg::slow_dual_doze : pm_pkg::slow_only_doze;
    return s ? pm_pkg::fast_dual_doze : pm_pkg::fast_single_doze;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; order is {time base, reset pin, wake pin}
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 3'h2;
      pin_sync <= 3'h2;
      pin_last <= 3'h2;
    end else begin
      pin_meta <= {tb_source_clk, reset_pin_n, wake_pin_in};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // edges are taken only from the second flop onward
  assign wake_s    = pin_sync[0];
  assign rst_pin_s = pin_sync[1];
  assign wake_rise = pin_sync[0] & ~pin_last[0];
  assign tb_fall   = ~pin_sync[2] & pin_last[2];   // [R23]
  assign soft_rst  = ~rst_pin_s | rst_req;          // [R7]

  ////////////////////////////////////////////////////////////////////////////
  // write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_ok   <= 1'b0;
      w_ok    <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= pm_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_ok   <= 1'b1;
        awready <= 1'b0;
      end else if (!aw_ok && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_ok   <= 1'b1;
        wready <= 1'b0;
      end else if (!w_ok && !bvalid) begin
        wready <= 1'b1;
      end
      if (do_write) begin
        aw_ok  <= 1'b0;
        w_ok   <= 1'b0;
        bvalid <= 1'b1;
        bresp  <= (aw_addr == pm_pkg::ADDR_A || aw_addr == pm_pkg::ADDR_B) ?
                  pm_pkg::RESP_OKAY : pm_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // register strobes; only byte lane 0 carries register bits
  assign do_write = aw_ok & w_ok & ~bvalid;
  assign wr_a     = do_write & (aw_addr == pm_pkg::ADDR_A) & w_strb[0];
  assign wr_b     = do_write & (aw_addr == pm_pkg::ADDR_B) & w_strb[0];
  assign nb       = pm_pkg::pcrb_t'(w_data[7:0]);
  // removing the oscillator of the running clock is fatal
  assign bad_write = wr_b & ((~nb.fast_osc_on & ~nb.slow_osc_on) |
                             (~nb.fast_osc_on & ~clk_slow) |
                             (~nb.slow_osc_on & clk_slow));   // [R16]

  ////////////////////////////////////////////////////////////////////////////
  // read channel; undefined bits answer zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= pm_pkg::RESP_OKAY;
    end else if (rvalid) begin
      if (rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end else if (arvalid && arready) begin
      rvalid  <= 1'b1;
      arready <= 1'b0;
      rresp   <= pm_pkg::RESP_OKAY;
      if (araddr == pm_pkg::ADDR_A) begin
        rdata <= {24'h00_0000, ra[7:2], 2'h0};                    // [R8]
      end else if (araddr == pm_pkg::ADDR_B) begin
        rdata <= {24'h00_0000, rb.fast_osc_on, rb.slow_osc_on,
                  clk_slow, rb.cpu_doze_request, 1'b0,
                  rb.peripheral_clock_gate, 2'h0};                // [R13] [R17]
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= pm_pkg::RESP_SLVERR;
      end
    end else begin
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // a bad write resets the block one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_req <= 1'b0;
    end else begin
      rst_req <= bad_write & ~soft_rst;   // [R16]
    end
  end

  // halt controls; request self-clears when warm-up ends
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      ra <= pm_pkg::pcra_t'(pm_pkg::PCRA_RESET);
    end else begin
      if (wr_a) begin
        ra <= pm_pkg::pcra_t'(w_data[7:0]);
      end
      if (warm_done) begin
        ra.deep_halt_request <= 1'b0;
      end
    end
  end

  // oscillator, clock and doze controls
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      rb       <= pm_pkg::pcrb_t'(pm_pkg::PCRB_RESET);
      clk_slow <= 1'b0;
    end else begin
      if (wr_b) begin
        rb <= nb;                                                 // [R11] [R12]
        // switch only onto an oscillator that stays on
        if (nb.core_clock_select && nb.slow_osc_on) begin
          clk_slow <= 1'b1;                                       // [R13]
        end else if (!nb.core_clock_select && nb.fast_osc_on) begin
          clk_slow <= 1'b0;                                       // [R13]
        end
      end
      if (is_doze && wake_irq) begin
        rb.cpu_doze_request <= 1'b0;                              // [R19]
      end
      if (is_base && tb_fall) begin
        rb.peripheral_clock_gate <= 1'b0;                         // [R20]
        // single-oscillator return drops the other oscillator
        if (state == pm_pkg::fast_base_doze) begin
          rb.slow_osc_on <= 1'b0;
        end else begin
          rb.fast_osc_on <= 1'b0;
        end
      end
      if (warm_done) begin
        rb.fast_osc_on <= ~ra.wake_target_select;                 // [R3]
        clk_slow       <= ra.wake_target_select;
        if (ra.wake_target_select) begin
          rb.slow_osc_on <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state classes
  assign is_run  = (state == pm_pkg::fast_single_run) || (state == pm_pkg::fast_dual_run) ||
                   (state == pm_pkg::slow_only_run) || (state == pm_pkg::slow_dual_run);
  assign is_base = (state == pm_pkg::fast_base_doze) || (state == pm_pkg::slow_base_doze);
  assign is_doze = !is_run && !is_base &&
                   (state != pm_pkg::deep_halt) && (state != pm_pkg::warm_up);

  // operating state machine
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      state <= pm_pkg::fast_single_run;                           // [R7]
    end else begin
      unique case (state)                                         // [R26]
        pm_pkg::fast_single_run, pm_pkg::fast_dual_run,
        pm_pkg::slow_only_run, pm_pkg::slow_dual_run: begin
          if (ra.deep_halt_request) begin
            // level release with the pin already high skips the halt
            state <= (ra.wake_level_select && wake_s) ?
                     pm_pkg::warm_up : pm_pkg::deep_halt;         // [R1] [R25]
          end else if (rb.cpu_doze_request) begin
            // doze wins if software sets both bits        [R18]
            state <= doze_of(rb.fast_osc_on, rb.slow_osc_on, clk_slow);  // [R14]
          end else if (rb.peripheral_clock_gate) begin
            state <= clk_slow ? pm_pkg::slow_base_doze :
                                pm_pkg::fast_base_doze;           // [R15]
          end else begin
            state <= run_of(rb.fast_osc_on, rb.slow_osc_on, clk_slow);
          end
        end
        pm_pkg::fast_single_doze, pm_pkg::fast_dual_doze,
        pm_pkg::slow_only_doze, pm_pkg::slow_dual_doze: begin
          if (wake_irq) begin
            state <= run_of(rb.fast_osc_on, rb.slow_osc_on, clk_slow);
          end
        end
        // the time base is asynchronous, so doze can end early   [R21]
        pm_pkg::fast_base_doze: begin
          if (tb_fall) state <= pm_pkg::fast_single_run;          // [R23]
        end
        pm_pkg::slow_base_doze: begin
          if (tb_fall) state <= pm_pkg::slow_only_run;            // [R23]
        end
        pm_pkg::deep_halt: begin
          if (ra.wake_level_select ? wake_s : wake_rise) begin
            state <= pm_pkg::warm_up;                             // [R2] [R25]
          end
        end
        pm_pkg::warm_up: begin
          if (warm_done) begin
            state <= ra.wake_target_select ? pm_pkg::slow_only_run :
                     (rb.slow_osc_on ? pm_pkg::fast_dual_run :
                                       pm_pkg::fast_single_run);  // [R3]
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // warm-up length, counted in periods of the returning oscillator
  always_comb begin
    warm_limit = WARM_FAST_00;
    if (ra.wake_target_select) begin
      unique case (ra.warmup_select)
        2'h0: warm_limit = WARM_SLOW_00;                          // [R5]
        2'h1: warm_limit = WARM_SLOW_01;
        2'h2: warm_limit = pm_pkg::WARM_SLOW_10;
        2'h3: warm_limit = pm_pkg::WARM_SLOW_11;
      endcase
    end else begin
      unique case (ra.warmup_select)
        2'h0: warm_limit = WARM_FAST_00;                          // [R5]
        2'h1: warm_limit = WARM_FAST_01;
        2'h2: warm_limit = WARM_FAST_10;
        2'h3: warm_limit = WARM_FAST_11;
      endcase
    end
  end

  assign warm_tick = ra.wake_target_select ? slow_tick : fast_tick;
  assign warm_done = (state == pm_pkg::warm_up) && (warm_cnt == warm_limit);

  // counter idles at zero outside warm-up
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst || state != pm_pkg::warm_up) begin
      warm_cnt <= 18'h0_0000;
    end else if (warm_tick && !warm_done) begin
      warm_cnt <= 18'(warm_cnt + 18'h0_0001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs, one cycle behind the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_osc_enable  <= 1'b1;
      slow_osc_enable  <= 1'b0;
      core_clk_slow    <= 1'b0;
      cpu_wdt_stop     <= 1'b0;
      periph_clk_stop  <= 1'b0;
      port_out_hiz     <= 1'b0;
      port_in_zero     <= 1'b0;
      wake_pin_hiz     <= 1'b0;
      prescaler_clear  <= 1'b0;
      warmup_busy      <= 1'b0;
      mode             <= pm_pkg::fast_single_run;
    end else begin
      if (state == pm_pkg::deep_halt) begin
        fast_osc_enable <= 1'b0;                                  // [R1]
        slow_osc_enable <= 1'b0;
      end else if (state == pm_pkg::warm_up) begin
        fast_osc_enable <= ~ra.wake_target_select;
        slow_osc_enable <= ra.wake_target_select | rb.slow_osc_on;
      end else begin
        fast_osc_enable <= rb.fast_osc_on;                        // [R11]
        slow_osc_enable <= rb.slow_osc_on;                        // [R12]
      end
      core_clk_slow   <= clk_slow;
      cpu_wdt_stop    <= ~is_run;                                 // [R14]
      periph_clk_stop <= ~is_run & ~is_doze;                      // [R15]
      port_out_hiz    <= (state == pm_pkg::deep_halt) & ~ra.halt_output_hold;  // [R4]
      port_in_zero    <= (state == pm_pkg::deep_halt) & ~ra.halt_output_hold;  // [R9]
      wake_pin_hiz    <= (state == pm_pkg::deep_halt);            // [R10]
      prescaler_clear <= (state == pm_pkg::deep_halt);            // [R24]
      warmup_busy     <= (state == pm_pkg::warm_up);
      mode            <= state;
    end
  end

  assign system_reset_req = rst_req;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_halt_clocks_off: assert property (state == pm_pkg::deep_halt && !soft_rst |=> // [R1]
    !fast_osc_enable && !slow_osc_enable && prescaler_clear && cpu_wdt_stop)
    else $error("deep halt left an oscillator running");
  a_wake_pin_float: assert property (state == pm_pkg::deep_halt |=> wake_pin_hiz) // [R10]
    else $error("wake pin driven in deep halt");
  a_port_float: assert property ($rose(port_in_zero) |-> // [R9]
    port_out_hiz && $past(!ra.halt_output_hold) && mode == pm_pkg::deep_halt)
    else $error("port float without float mode");
  a_edge_release: assert property (state == pm_pkg::deep_halt && !soft_rst && // [R25]
    !ra.wake_level_select |=> (state == pm_pkg::warm_up) == $past(wake_rise))
    else $error("edge release mismatch");
  a_level_release: assert property (state == pm_pkg::deep_halt && !soft_rst && // [R2]
    ra.wake_level_select && wake_s |=> state == pm_pkg::warm_up)
    else $error("level release missed");
  a_slow_return: assert property (warm_done && !soft_rst && ra.wake_target_select // [R3]
    |=> state == pm_pkg::slow_only_run && clk_slow ##1 core_clk_slow)
    else $error("slow return wrong");
  a_pin_reset: assert property (!rst_pin_s |=> // [R7]
    state == pm_pkg::fast_single_run && !ra.deep_halt_request && !clk_slow)
    else $error("reset pin did not return to fast run");
  a_doze_clear: assert property (is_doze && wake_irq && !soft_rst && !wr_b |=> // [R19]
    !rb.cpu_doze_request && is_run)
    else $error("doze bit not cleared on exit");
  a_gate_clear: assert property (is_base && tb_fall && !soft_rst && !wr_b |=> // [R20]
    !rb.peripheral_clock_gate && is_run)
    else $error("gate bit not cleared on exit");
  a_bad_write: assert property (bad_write && !soft_rst |=> // [R16]
    system_reset_req ##1 (rb == pm_pkg::pcrb_t'(pm_pkg::PCRB_RESET)) && !system_reset_req)
    else $error("clock removal did not reset");

  c_halt_cycle: cover property (state == pm_pkg::deep_halt ##1 state == pm_pkg::warm_up);
  c_doze_exit: cover property (is_doze ##1 is_run);
  c_base_exit: cover property (is_base ##1 is_run);
  c_bad_write: cover property (bad_write);

endmodule // power_mode_control

// *** tb_top.sv ***
// self-checking bench for power_mode_control
// assumes pm_pkg is compiled first; the bench drives every port itself
`timescale 1ns/1ps
module tb_top;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [1:0]  r;
  } row_t;
  localparam logic [11:0] RA = pm_pkg::ADDR_A;
  localparam logic [11:0] RB = pm_pkg::ADDR_B;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, rdata, got;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic        rready = 1'h0, wake_pin_in = 1'h1, reset_pin_n = 1'h1;
  logic        tb_source_clk = 1'h1, wake_irq = 1'h0, fast_tick = 1'h0, slow_tick = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, fast_osc_enable, slow_osc_enable;
  logic        core_clk_slow, cpu_wdt_stop, periph_clk_stop, port_out_hiz, port_in_zero;
  logic        wake_pin_hiz, prescaler_clear, warmup_busy, system_reset_req;
  logic [1:0]  bresp, rresp, resp;
  pm_pkg::power_mode_t mode;
  int          err_count = 0, checks = 0, n;
  row_t        rows [10] = '{
    '{1'h0, RA, 8'h00, 8'h00, 2'h0}, '{1'h0, RB, 8'h00, 8'h80, 2'h0},
    '{1'h1, RA, 8'h0f, 8'h00, 2'h0}, '{1'h0, RA, 8'h00, 8'h0c, 2'h0},
    '{1'h1, RB, 8'hcb, 8'h00, 2'h0}, '{1'h0, RB, 8'h00, 8'hc0, 2'h0},
    '{1'h1, RB, 8'he0, 8'h00, 2'h0}, '{1'h0, RB, 8'h00, 8'he0, 2'h0},
    '{1'h1, 12'h100, 8'h55, 8'h00, 2'h2}, '{1'h0, 12'h100, 8'h00, 8'h00, 2'h2}};

  ////////////////////////////////////////////////////////////////////////////
  // clock, and tick stand-ins at half the bus rate
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    fast_tick <= ~fast_tick;
    slow_tick <= ~slow_tick;
  end

  // short fast warm-up keeps the run brief
  power_mode_control #(.WARM_FAST_11(18'h0_0010)) u_power_mode_control (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .wake_pin_in, .reset_pin_n, .tb_source_clk, .wake_irq, .fast_tick, .slow_tick,
    .fast_osc_enable, .slow_osc_enable, .core_clk_slow, .cpu_wdt_stop, .periph_clk_stop,
    .port_out_hiz, .port_in_zero, .wake_pin_hiz, .prescaler_clear, .warmup_busy,
    .system_reset_req, .mode);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // readiness is looked at mid-cycle, so the edge that takes it is known
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic ta, tw, tk;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h00_0000, d}; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    // no local limit: a hung answer is left to the watchdog
    do begin
      @(negedge aclk);
      ta = awvalid & awready; tw = wvalid & wready; tk = bvalid; resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end while (!tk);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a);
    logic ta, tk;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do begin
      @(negedge aclk);
      ta = arvalid & arready; tk = rvalid; got = rdata; resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'h0;
    end while (!tk);
    rready <= 1'h0;
  endtask

  task automatic idle(input int k);
    repeat (k) @(negedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence: table first, then the awkward cases
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      else rd(rows[i].a);
      chk(32'(resp), 32'(rows[i].r));
      if (!rows[i].w) chk(got, {24'h00_0000, rows[i].e});
    end
    wr(RB, 8'hc0);
    idle(4);
    chk({core_clk_slow, fast_osc_enable, slow_osc_enable}, 3'h3);
    $display("register table done");
    // entered with the wake pin already high, edge release
    wr(RA, 8'h8c);
    idle(4);
    chk({mode, port_out_hiz, port_in_zero, wake_pin_hiz, prescaler_clear, fast_osc_enable},
        {pm_pkg::deep_halt, 5'h1e});
    @(posedge aclk) wake_pin_in <= 1'h0;
    idle(6);
    chk(32'(mode), 32'(pm_pkg::deep_halt));
    @(posedge aclk) wake_pin_in <= 1'h1;
    n = 0;
    while (mode !== pm_pkg::fast_dual_run && n < 200) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n >= 32 && n < 60), 32'h1);
    rd(RA);
    chk(got, 32'h0000_000c);
    $display("edge release done");
    wr(RA, 8'hcc);
    idle(4);
    chk(32'(mode), 32'(pm_pkg::warm_up));
    idle(60);
    // halt entered from slow run returns slow, after the slow warm-up
    @(posedge aclk) wake_pin_in <= 1'h0;
    wr(RB, 8'he0);
    wr(RA, 8'hac);
    idle(4);
    @(posedge aclk) wake_pin_in <= 1'h1;
    idle(100);
    chk({mode, warmup_busy}, {pm_pkg::warm_up, 1'h1});
    idle(50);
    chk({mode, core_clk_slow, fast_osc_enable}, {pm_pkg::slow_only_run, 2'h2});
    wr(RA, 8'hac);
    idle(4);
    @(posedge aclk) reset_pin_n <= 1'h0;
    idle(6);
    chk(32'(mode), 32'(pm_pkg::fast_single_run));
    @(posedge aclk) reset_pin_n <= 1'h1;
    $display("reset pin release done");
    wr(RB, 8'h90);
    idle(4);
    chk({mode, cpu_wdt_stop}, {pm_pkg::fast_single_doze, 1'h1});
    @(posedge aclk) wake_irq <= 1'h1;
    @(posedge aclk) wake_irq <= 1'h0;
    rd(RB);
    chk({got[30:0], cpu_wdt_stop}, 32'h0000_0100);
    wr(RB, 8'h84);
    idle(4);
    chk({mode, periph_clk_stop}, {pm_pkg::fast_base_doze, 1'h1});
    @(posedge aclk) tb_source_clk <= 1'h0;
    // the fall passes two flops and the state edge before the bit clears
    idle(4);
    rd(RB);
    chk({got[30:0], periph_clk_stop}, 32'h0000_0100);
    @(posedge aclk) tb_source_clk <= 1'h1;
    $display("doze exits done");
    // the pulse comes before the write handshake ends, so watch alongside it
    n = 0;
    fork
      wr(RB, 8'h40);
      repeat (12) @(negedge aclk) if (system_reset_req === 1'h1) n++;
    join
    chk(32'(n), 32'h1);
    rd(RB);
    chk(got, 32'h0000_0080);
    $display("clock removal reset done");
    end_of_test();
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #100us;
    err_count++;
    end_of_test();
  end
endmodule // tb_top
